// ==== rtl/bit_and_literal_exec_unit.sv ====
// Decode and execute of literal AND, bit clear, bit set and bit test with skip
`timescale 1ns/1ps
`include "bit_exec_defines.svh"

module bit_and_literal_exec_unit #(
    parameter int DATA_W   = 8,   // Data register width
    parameter int NUM_REGS = 32   // Data registers addressed
) (
    input  wire logic                  clk_sys_in,      // Core instruction clock
    input  wire logic                  nrst_in,         // Synchronous reset, low active
    input  wire logic                  ce_in,           // Clock enable, freezes all state
    input  wire logic                  instr_valid_in,  // Fetched word present
    input  wire logic [11:0]           instr_in,        // Fetched instruction word
    input  wire bit_exec_pkg::reg_write_t ext_wr_in,    // Outside write into register file
    input  wire bit_exec_pkg::acc_load_t  acc_ld_in,    // Outside load of the accumulator
    input  wire logic [4:0]            rd_addr_in,      // Register to show on rd_data_out
    output logic [DATA_W-1:0]          accum_out,       // Accumulator
    output logic                       zero_out,        // Zero flag
    output logic                       flush_out,       // Current fetched word is discarded
    output logic [DATA_W-1:0]          rd_data_out      // Registered readback
);

    // Decode one word into its fields
    function automatic bit_exec_pkg::decoded_t decode(input logic [11:0] w);
        bit_exec_pkg::decoded_t d;
        d.immediate_operand = w[`FLD_POS_MSB:`FLD_SEL_LSB];
        d.position_index    = w[`FLD_POS_MSB:`FLD_POS_LSB];
        d.register_select   = w[`FLD_SEL_MSB:`FLD_SEL_LSB];
        case (w[`FLD_OPC_MSB:`FLD_OPC_LSB])
            `OPC_AND_LITERAL:   d.kind = bit_exec_pkg::OP_AND_LITERAL;
            `OPC_BIT_CLEAR:     d.kind = bit_exec_pkg::OP_BIT_CLEAR;
            `OPC_BIT_SET:       d.kind = bit_exec_pkg::OP_BIT_SET;
            `OPC_BIT_TEST_SKIP: d.kind = bit_exec_pkg::OP_BIT_TEST_SKIP;
            default:            d.kind = bit_exec_pkg::OP_NONE;
        endcase
        return d;
    endfunction

    // Replace one bit of a register value
    function automatic logic [DATA_W-1:0] put_bit(input logic [DATA_W-1:0] v,
                                                  input logic [2:0] pos,
                                                  input logic b);
        logic [DATA_W-1:0] r;
        r      = v;
        r[pos] = b;
        return r;
    endfunction

    logic [DATA_W-1:0]      regs_q [NUM_REGS];
    logic [DATA_W-1:0]      accum_q;
    logic [DATA_W-1:0]      accum_d;
    logic                   zero_q;
    logic                   zero_d;
    logic                   flush_q;
    logic                   flush_d;
    logic [DATA_W-1:0]      rd_q;
    logic [DATA_W-1:0]      rd_d;
    bit_exec_pkg::decoded_t dec;
    bit_exec_pkg::reg_write_t wr;
    logic                   exec;
    logic [DATA_W-1:0]      sel_val;
    logic                   test_bit;
    logic [DATA_W-1:0]      and_res;

    // Decode and operand fetch from the register file
    always_comb begin
        dec      = decode(instr_in);
        exec     = instr_valid_in && !flush_q;
        sel_val  = regs_q[dec.register_select];
        test_bit = sel_val[dec.position_index];
        and_res  = accum_q & dec.immediate_operand;
    end

    // Next state of accumulator, flag, skip and register write
    always_comb begin
        // Without a load path the accumulator could never leave its reset value
        accum_d = acc_ld_in.en ? acc_ld_in.data : accum_q; // A literal AND below wins
        zero_d  = zero_q;
        flush_d = 1'b0;
        wr      = ext_wr_in;
        rd_d    = regs_q[rd_addr_in];
        if (exec) begin
            case (dec.kind)
                bit_exec_pkg::OP_AND_LITERAL: begin
                    accum_d = and_res;
                    zero_d  = (and_res == '0);
                end
                bit_exec_pkg::OP_BIT_CLEAR: begin
                    wr.en   = 1'b1;
                    wr.addr = dec.register_select;
                    wr.data = put_bit(sel_val, dec.position_index, 1'b0);
                end
                bit_exec_pkg::OP_BIT_SET: begin
                    wr.en   = 1'b1;
                    wr.addr = dec.register_select;
                    wr.data = put_bit(sel_val, dec.position_index, 1'b1);
                end
                bit_exec_pkg::OP_BIT_TEST_SKIP: begin
                    // The following word is already in flight, so it is squashed next cycle
                    flush_d = !test_bit;
                end
                default: begin
                    flush_d = 1'b0; // Other opcodes run as no-ops
                end
            endcase
        end
    end

    // State registers; instruction write wins over an outside write
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            accum_q <= `RST_ACCUM;
            zero_q  <= `RST_ZERO;
            flush_q <= 1'b0;
            rd_q    <= `RST_DATA_REG;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= `RST_DATA_REG;
            end
        end else if (ce_in) begin
            accum_q <= accum_d;
            zero_q  <= zero_d;
            flush_q <= flush_d;
            rd_q    <= rd_d;
            if (wr.en) begin
                regs_q[wr.addr] <= wr.data;
            end
        end
    end

    // Outputs straight from flops
    assign accum_out   = accum_q;
    assign zero_out    = zero_q;
    assign flush_out   = flush_q;
    assign rd_data_out = rd_q;

    // Checks on the execute behaviour
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    a_and_result: assert property (
        ce_in && exec && dec.kind == bit_exec_pkg::OP_AND_LITERAL
        |=> accum_q == ($past(accum_q) & $past(instr_in[7:0])))
        else $error("literal AND result wrong");

    a_and_zero_flag: assert property (
        ce_in && exec && dec.kind == bit_exec_pkg::OP_AND_LITERAL
        |=> zero_q == ((($past(accum_q) & $past(instr_in[7:0]))) == 8'h00))
        else $error("zero flag wrong after literal AND");

    a_clear_bit: assert property (
        ce_in && exec && dec.kind == bit_exec_pkg::OP_BIT_CLEAR
        |=> regs_q[$past(instr_in[4:0])][$past(instr_in[7:5])] == 1'b0)
        else $error("bit not cleared");

    a_set_bit: assert property (
        ce_in && exec && dec.kind == bit_exec_pkg::OP_BIT_SET
        |=> regs_q[$past(instr_in[4:0])][$past(instr_in[7:5])] == 1'b1)
        else $error("bit not set");

    a_bit_flags_keep: assert property (
        ce_in && exec && dec.kind != bit_exec_pkg::OP_AND_LITERAL && !acc_ld_in.en
        |=> zero_q == $past(zero_q) && accum_q == $past(accum_q))
        else $error("bit instruction altered flags");

    a_skip_taken: assert property (
        ce_in && exec && dec.kind == bit_exec_pkg::OP_BIT_TEST_SKIP
        && regs_q[instr_in[4:0]][instr_in[7:5]] == 1'b0
        |=> flush_q)
        else $error("skip not taken on clear bit");

    a_skip_not_taken: assert property (
        ce_in && exec && dec.kind == bit_exec_pkg::OP_BIT_TEST_SKIP
        && regs_q[instr_in[4:0]][instr_in[7:5]] == 1'b1
        |=> !flush_q)
        else $error("skip taken on set bit");

    a_flush_is_nop: assert property (
        ce_in && flush_q && !ext_wr_in.en && !acc_ld_in.en
        |=> accum_q == $past(accum_q) && zero_q == $past(zero_q) && !flush_q)
        else $error("discarded word had an effect");

    a_flush_one_cycle: assert property (
        flush_q && ce_in |=> !flush_q)
        else $error("flush held beyond one cycle");

    // Checks on untouched bits, side paths and the clock enable
    a_clear_keeps_rest: assert property (
        ce_in && exec && dec.kind == bit_exec_pkg::OP_BIT_CLEAR
        |=> (regs_q[$past(instr_in[4:0])] | (8'h01 << $past(instr_in[7:5])))
            == ($past(sel_val) | (8'h01 << $past(instr_in[7:5]))))
        else $error("bit clear disturbed other bits");

    a_set_keeps_rest: assert property (
        ce_in && exec && dec.kind == bit_exec_pkg::OP_BIT_SET
        |=> (regs_q[$past(instr_in[4:0])] & ~(8'h01 << $past(instr_in[7:5])))
            == ($past(sel_val) & ~(8'h01 << $past(instr_in[7:5]))))
        else $error("bit set disturbed other bits");

    a_test_no_write: assert property (
        ce_in && exec && dec.kind == bit_exec_pkg::OP_BIT_TEST_SKIP && !ext_wr_in.en
        |=> regs_q[$past(instr_in[4:0])] == $past(sel_val))
        else $error("bit test changed its register");

    a_flush_only_skip: assert property (
        ce_in && !(exec && dec.kind == bit_exec_pkg::OP_BIT_TEST_SKIP)
        |=> !flush_q)
        else $error("flush without a bit test");

    a_acc_load_lands: assert property (
        ce_in && acc_ld_in.en && !(exec && dec.kind == bit_exec_pkg::OP_AND_LITERAL)
        |=> accum_q == $past(acc_ld_in.data))
        else $error("accumulator load lost");

    a_ext_write_lands: assert property (
        ce_in && ext_wr_in.en && !(exec && (dec.kind == bit_exec_pkg::OP_BIT_CLEAR
                                            || dec.kind == bit_exec_pkg::OP_BIT_SET))
        |=> regs_q[$past(ext_wr_in.addr)] == $past(ext_wr_in.data))
        else $error("outside register write lost");

    a_ce_freeze: assert property (
        !ce_in
        |=> accum_q == $past(accum_q) && zero_q == $past(zero_q)
            && flush_q == $past(flush_q) && rd_q == $past(rd_q))
        else $error("state moved with clock enable low");

endmodule

// ==== rtl/bit_exec_defines.svh ====
// Constants for the bit and literal execute unit
// Functional notes
// - An instruction with upper nibble 1110 ANDs its 8-bit immediate into the accumulator in one cycle, touching only the zero flag.
// - An instruction with upper nibble 0100 clears the addressed bit of the selected data register in one cycle, flags untouched.
// - An instruction with upper nibble 0101 sets the addressed bit of the selected data register in one cycle, flags untouched.
// - Bit instructions select one of data registers 0 to 31 with a 5-bit field and one of bits 0 to 7 with a 3-bit field.
// - An instruction with upper nibble 0110 skips the next instruction when the addressed bit reads zero, flags untouched.
// - Fetch overlaps execution, so the next instruction is already fetched while the current one executes.
// - A taken skip discards the fetched instruction and runs a no-operation instead, two cycles in all; otherwise one cycle.
`ifndef BIT_EXEC_DEFINES_SVH
`define BIT_EXEC_DEFINES_SVH

// Upper nibble opcodes
`define OPC_AND_LITERAL   4'he
`define OPC_BIT_CLEAR     4'h4
`define OPC_BIT_SET       4'h5
`define OPC_BIT_TEST_SKIP 4'h6

// Field positions in the 12-bit word
`define FLD_OPC_MSB       11
`define FLD_OPC_LSB       8
`define FLD_POS_MSB       7
`define FLD_POS_LSB       5
`define FLD_SEL_MSB       4
`define FLD_SEL_LSB       0

// Reset values
`define RST_ACCUM         8'h00
`define RST_ZERO          1'b0
`define RST_DATA_REG      8'h00

`endif

// ==== rtl/bit_exec_pkg.sv ====
// Types for the bit and literal execute unit
package bit_exec_pkg;

    // Decoded operation kinds
    typedef enum logic [2:0] {
        OP_NONE,
        OP_AND_LITERAL,
        OP_BIT_CLEAR,
        OP_BIT_SET,
        OP_BIT_TEST_SKIP
    } op_kind_t;

    // Fields of one decoded instruction word
    typedef struct packed {
        op_kind_t   kind;
        logic [7:0] immediate_operand;
        logic [2:0] position_index;
        logic [4:0] register_select;
    } decoded_t;

    // Side write into the data register file
    typedef struct packed {
        logic       en;
        logic [4:0] addr;
        logic [7:0] data;
    } reg_write_t;

    // Outside load of the accumulator by instructions handled elsewhere
    typedef struct packed {
        logic       en;
        logic [7:0] data;
    } acc_load_t;

endpackage

// ==== bench/prog_fetch_model.sv ====
// Program memory fetch stage that feeds one word per cycle
`timescale 1ns/1ps
module prog_fetch_model (
    input  wire logic        clk_sys_in,      // Core instruction clock
    input  wire logic        nrst_in,         // Synchronous reset, low active
    input  wire logic        run_in,          // Fetch enable
    output logic             instr_valid_out, // Word present
    output logic [11:0]      instr_out        // Fetched word
);
    logic [11:0] prog [0:1023];
    logic [9:0]  pc_q;

    // Next word fetched while the current one executes; a taken skip is not seen here
    always @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            pc_q            <= 10'h000;
            instr_valid_out <= 1'b0;
            instr_out       <= 12'h000;
        end else if (run_in) begin
            instr_out       <= prog[pc_q];
            instr_valid_out <= 1'b1;
            pc_q            <= pc_q + 10'h001;
        end else begin
            instr_valid_out <= 1'b0;
            instr_out       <= ~instr_out; // Idle bus toggles, never a stale word
        end
    end
endmodule

// ==== bench/bit_and_literal_exec_unit_tb.sv ====
// Random program run against a cycle model of the execute unit
`timescale 1ns/1ps
module bit_and_literal_exec_unit_tb;
    typedef struct packed {logic [7:0] acc; logic z; logic fl; logic [7:0] rd;} note_t;
    localparam int N = 600;
    logic                      clk_sys_in = 1'b0;
    logic                      nrst_in    = 1'b0;
    logic                      run        = 1'b0;
    logic                      ce         = 1'b1;
    logic                      ce_a [N];
    logic                      live       = 1'b0;
    logic                      valid;
    logic [11:0]               instr;
    bit_exec_pkg::reg_write_t  ext_wr     = '0;
    bit_exec_pkg::reg_write_t  wr [N];
    bit_exec_pkg::acc_load_t   acc_ld     = '0;
    bit_exec_pkg::acc_load_t   ld [N];
    logic [4:0]                rd_addr    = 5'h00;
    logic [4:0]                ra [N];
    logic [7:0]                acc_out, rd_out, acc, regs [32];
    logic                      zero_out, flush_out, z, fl, nf, wrote, anded;
    logic [11:0]               w;
    note_t                     q [$];
    note_t                     n;
    int                        bad_count = 0, cmp_count = 0, seed = 42757, r, t;

    bit_and_literal_exec_unit i_bit_and_literal_exec_unit (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .ce_in(ce), .instr_valid_in(valid), .instr_in(instr), .ext_wr_in(ext_wr), .acc_ld_in(acc_ld),
        .rd_addr_in(rd_addr), .accum_out(acc_out), .zero_out(zero_out), .flush_out(flush_out),
        .rd_data_out(rd_out));
    prog_fetch_model i_prog_fetch_model (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .run_in(run),
        .instr_valid_out(valid), .instr_out(instr));

    initial forever #2 clk_sys_in = ~clk_sys_in;

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Low and high ends of the register range, so tests hit recent writes
    function logic [4:0] pick(input int v);
        return {v[2], v[2], v[2], v[1:0]};
    endfunction

    // Watcher: one note per executed cycle, settled one step after the edge
    always @(posedge clk_sys_in) begin
        #1;
        if (live && q.size() > 0) begin
            n = q.pop_front();
            chk("accum", acc_out, n.acc);
            chk("zero", {7'h00, zero_out}, {7'h00, n.z});
            chk("flush", {7'h00, flush_out}, {7'h00, n.fl});
            chk("readback", rd_out, n.rd);
        end
    end

    initial begin
        acc = 8'h00;
        z = 1'b0;
        fl = 1'b0;
        foreach (regs[j]) regs[j] = 8'h00;
        // Program and per-cycle side traffic, with expected results noted up front
        for (int i = 0; i < N; i++) begin
            r = $random(seed);
            case ($unsigned(r) % 5)
                0: w = {4'he, r[15:8]};
                1: w = {4'h4, r[10:8], pick(r >> 12)};
                2: w = {4'h5, r[10:8], pick(r >> 12)};
                3: w = {4'h6, r[10:8], pick(r >> 12)};
                default: w = {2'b10, r[9:8], r[19:12]}; // Other opcodes run as no-ops
            endcase
            i_prog_fetch_model.prog[i] = w;
            r = $random(seed);
            wr[i] = {r[3:0] == 4'h0, pick(r >> 4), r[15:8]};
            ra[i] = pick(r >> 16);
            r = $random(seed);
            ld[i] = {r[2:0] == 3'h0, r[15:8]};
            ce_a[i] = (r[23:21] != 3'h0); // Frozen cycles lose their word and side traffic
            wrote = 1'b0;
            anded = 1'b0;
            nf = fl;
            if (ce_a[i]) begin
                n.rd = regs[ra[i]];
                nf = 1'b0;
                if (!fl) begin
                    case (w[11:8])
                        4'he: begin acc = acc & w[7:0]; z = (acc == 8'h00); anded = 1'b1; end
                        4'h4: begin regs[w[4:0]][w[7:5]] = 1'b0; wrote = 1'b1; end
                        4'h5: begin regs[w[4:0]][w[7:5]] = 1'b1; wrote = 1'b1; end
                        4'h6: nf = !regs[w[4:0]][w[7:5]];
                        default: ;
                    endcase
                end
                if (ld[i].en && !anded) acc = ld[i].data;
                if (wr[i].en && !wrote) regs[wr[i].addr] = wr[i].data;
            end
            fl = nf;
            q.push_back({acc, z, fl, n.rd});
        end
        i_prog_fetch_model.prog[N] = 12'h000;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("reset accum", acc_out, 8'h00);
        chk("reset flags", {6'h00, zero_out, flush_out}, 8'h00);
        chk("reset readback", rd_out, 8'h00);
        @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        run     <= 1'b1; // Fetch runs one cycle ahead, so word i meets side traffic i
        // Back-to-back words every cycle
        for (int i = 0; i < N; i++) begin
            @(posedge clk_sys_in);
            ce <= ce_a[i];
            acc_ld <= ld[i];
            ext_wr <= wr[i];
            rd_addr <= ra[i];
            if (i == 1) live <= 1'b1;
        end
        @(posedge clk_sys_in);
        run <= 1'b0;
        ext_wr <= '0;
        acc_ld <= '0;
        ce <= 1'b1;
        for (t = 0; t < 10 && q.size() > 0; t++) @(posedge clk_sys_in);
        if (q.size() > 0) bad_count++;
        print_verdict();
    end
endmodule
